//--- rtl/rrx_pkg.sv
package rrx_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RRX_OFF_CTRL = 8'h00;
  localparam logic [7:0] RRX_OFF_OPERAND = 8'h04;
  localparam logic [7:0] RRX_OFF_RESULT = 8'h08;
  localparam logic [7:0] RRX_OFF_STATUS = 8'h0c;
  localparam logic [7:0] RRX_OFF_COUNTER = 8'h10;
  localparam logic [7:0] RRX_OFF_STACK = 8'h14;
  localparam logic [7:0] RRX_OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] RRX_OFF_IRQ_MASK = 8'h1c;

  // Control register fields
  localparam int RRX_CTRL_RETURN = 0;
  localparam int RRX_CTRL_SHIFT = 1;
  localparam int RRX_CTRL_BYTE = 2;
  localparam int RRX_CTRL_BUSY = 8;

  // Status word fields
  localparam int RRX_SR_C = 0;
  localparam int RRX_SR_Z = 1;
  localparam int RRX_SR_N = 2;
  localparam int RRX_SR_IRQ_EN = 3;
  localparam int RRX_SR_CORE_OFF = 4;
  localparam int RRX_SR_OSC_OFF = 5;
  localparam int RRX_SR_V = 8;
  localparam int RRX_SR_PCHI_LSB = 12;
  localparam logic [15:0] RRX_SR_MASK = 16'h01ff;

  // Event bits
  localparam int RRX_EV_RETURN = 0;
  localparam int RRX_EV_SHIFT = 1;
  localparam int RRX_EV_OVF = 2;
  localparam int RRX_EV_W = 3;

  // Reset values and constants
  localparam logic [15:0] RRX_SR_RST = 16'h0000;
  localparam logic [19:0] RRX_PC_RST = 20'h00000;
  localparam logic [19:0] RRX_SP_RST = 20'h00000;
  localparam logic [19:0] RRX_SP_STEP = 20'h00002;
  localparam logic [15:0] RRX_OVF_W_LO = 16'h4000;
  localparam logic [15:0] RRX_OVF_W_HI = 16'hc000;
  localparam logic [7:0] RRX_OVF_B_LO = 8'h40;
  localparam logic [7:0] RRX_OVF_B_HI = 8'hc0;

  typedef enum logic [2:0] {
    RRX_ST_IDLE = 3'b001,
    RRX_ST_POP_SR = 3'b010,
    RRX_ST_POP_CNT = 3'b100
  } rrx_state_t;

endpackage

//--- rtl/rrx_shift_left.sv
`timescale 1ns/1ps
module rrx_shift_left (
  input wire logic [15:0] operand, // Value before shifting
  input wire logic byte_mode, // Byte form when high
  output logic [15:0] result, // Shifted value
  output logic carry, // Old top bit
  output logic negative, // Result sign
  output logic zero, // Result is zero
  output logic overflow // Sign changed
);
  import rrx_pkg::*;

  always_comb begin
    if (byte_mode) begin
      result = {8'h00, operand[6:0], 1'b0};
      carry = operand[7];
      negative = operand[6];
      zero = (operand[6:0] == 7'h00);
      overflow = (operand[7:0] >= RRX_OVF_B_LO) && (operand[7:0] < RRX_OVF_B_HI);
    end else begin
      result = {operand[14:0], 1'b0};
      carry = operand[15];
      negative = operand[14];
      zero = (operand[14:0] == 15'h0000);
      overflow = (operand >= RRX_OVF_W_LO) && (operand < RRX_OVF_W_HI);
    end
  end

endmodule

//--- rtl/rrx_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Return loads the status register from the stack top word.
// - That same word gives the program counter its top four bits.
// - Each pop during return adds two to the stack pointer.
// - A second pop gives the low sixteen counter bits, joined to the top four.
// - After return, execution resumes at the restored address.
// - Return restores negative, zero, carry and overflow from the popped word.
// - Return restores the oscillator-off, core-off and interrupt enable bits.
// - Shift left moves the operand up one bit, old top bit to carry, zero in bit 0.
// - Word shift flags overflow for operands from 4000h up to below c000h.
// - Byte shift flags overflow for bytes from 40h up to below c0h, else clears it.
// - Shift left sets negative from the result sign.
// - Shift left sets zero only when the result is zero.
// - Shift left puts the operand top bit before shifting into carry.
// - Shift left leaves the three mode bits unchanged.
module rrx_core (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic mem_req, // Stack read request
  output logic [19:0] mem_addr, // Stack word address
  input wire logic mem_ack, // Stack read done pulse
  input wire logic [15:0] mem_rdata, // Stack read word
  output logic [19:0] program_counter, // Program counter
  output logic [19:0] stack_pointer, // Stack pointer
  output logic [15:0] status_word, // Status register
  output logic busy, // Return in progress
  output logic irq // Interrupt level
);
  import rrx_pkg::*;

  rrx_state_t state;
  logic [15:0] operand;
  logic [15:0] result;
  logic [RRX_EV_W-1:0] irq_stat;
  logic [RRX_EV_W-1:0] irq_mask;
  logic [15:0] sh_result;
  logic sh_c;
  logic sh_n;
  logic sh_z;
  logic sh_v;
  logic wr_en;
  logic rd_setup;
  logic ctrl_wr;
  logic ret_go;
  logic shift_go;
  logic byte_go;
  logic pop_sr_done;
  logic pop_cnt_done;
  logic [RRX_EV_W-1:0] events;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign ctrl_wr = wr_en && (paddr == RRX_OFF_CTRL);
  assign ret_go = ctrl_wr && pwdata[RRX_CTRL_RETURN] && (state == RRX_ST_IDLE);
  assign shift_go = ctrl_wr && pwdata[RRX_CTRL_SHIFT] && !pwdata[RRX_CTRL_RETURN]
    && (state == RRX_ST_IDLE);
  assign byte_go = pwdata[RRX_CTRL_BYTE];
  assign pop_sr_done = (state == RRX_ST_POP_SR) && mem_req && mem_ack;
  assign pop_cnt_done = (state == RRX_ST_POP_CNT) && mem_req && mem_ack;

  always_comb begin
    next_pslverr = 1'b0;
    case (paddr)
      RRX_OFF_CTRL: next_prdata = {23'h000000, busy, 8'h00};
      RRX_OFF_OPERAND: next_prdata = {16'h0000, operand};
      RRX_OFF_RESULT: next_prdata = {16'h0000, result};
      RRX_OFF_STATUS: next_prdata = {16'h0000, status_word};
      RRX_OFF_COUNTER: next_prdata = {12'h000, program_counter};
      RRX_OFF_STACK: next_prdata = {12'h000, stack_pointer};
      RRX_OFF_IRQ_STAT: next_prdata = {29'h00000000, irq_stat};
      RRX_OFF_IRQ_MASK: next_prdata = {29'h00000000, irq_mask};
      default: begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b1;
      end
    endcase
  end

  // Read data and error sampled in setup, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (rd_setup) begin
        prdata <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= next_pslverr;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand <= 16'h0000;
      irq_mask <= '0;
    end else if (wr_en) begin
      if (paddr == RRX_OFF_OPERAND) begin
        operand <= pwdata[15:0];
      end
      if (paddr == RRX_OFF_IRQ_MASK) begin
        irq_mask <= pwdata[RRX_EV_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Shift datapath
  // ----------------------------------------------------------------
  rrx_shift_left u_shift (
    .operand(operand),
    .byte_mode(byte_go),
    .result(sh_result),
    .carry(sh_c),
    .negative(sh_n),
    .zero(sh_z),
    .overflow(sh_v)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= 16'h0000;
    end else if (shift_go) begin
      result <= sh_result;
    end
  end

  // ----------------------------------------------------------------
  // Return sequence
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RRX_ST_IDLE;
      mem_req <= 1'b0;
      mem_addr <= RRX_SP_RST;
    end else begin
      case (state)
        RRX_ST_IDLE: begin
          if (ret_go) begin
            state <= RRX_ST_POP_SR;
            mem_req <= 1'b1;
            mem_addr <= stack_pointer;
          end
        end
        RRX_ST_POP_SR: begin
          if (pop_sr_done) begin
            state <= RRX_ST_POP_CNT;
            mem_addr <= stack_pointer + RRX_SP_STEP;
          end
        end
        RRX_ST_POP_CNT: begin
          if (pop_cnt_done) begin
            state <= RRX_ST_IDLE;
            mem_req <= 1'b0;
          end
        end
        default: begin
          state <= RRX_ST_IDLE;
          mem_req <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else if (ret_go) begin
      busy <= 1'b1;
    end else if (pop_cnt_done) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_pointer <= RRX_SP_RST;
    end else if (pop_sr_done || pop_cnt_done) begin
      stack_pointer <= stack_pointer + RRX_SP_STEP;
    end else if (wr_en && paddr == RRX_OFF_STACK && state == RRX_ST_IDLE) begin
      stack_pointer <= pwdata[19:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter <= RRX_PC_RST;
    end else if (pop_sr_done) begin
      program_counter[19:16] <= mem_rdata[RRX_SR_PCHI_LSB +: 4];
    end else if (pop_cnt_done) begin
      program_counter[15:0] <= mem_rdata;
    end else if (wr_en && paddr == RRX_OFF_COUNTER && state == RRX_ST_IDLE) begin
      program_counter <= pwdata[19:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_word <= RRX_SR_RST;
    end else if (pop_sr_done) begin
      status_word <= mem_rdata & RRX_SR_MASK;
    end else if (shift_go) begin
      status_word[RRX_SR_C] <= sh_c;
      status_word[RRX_SR_N] <= sh_n;
      status_word[RRX_SR_Z] <= sh_z;
      status_word[RRX_SR_V] <= sh_v;
    end else if (wr_en && paddr == RRX_OFF_STATUS && state == RRX_ST_IDLE) begin
      status_word <= pwdata[15:0] & RRX_SR_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign events = {shift_go && sh_v, shift_go, pop_cnt_done};

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else if (wr_en && paddr == RRX_OFF_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~pwdata[RRX_EV_W-1:0]) | events;
    end else begin
      irq_stat <= irq_stat | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sr_restore: assert property (pop_sr_done |=>
    status_word == ($past(mem_rdata) & RRX_SR_MASK))
    else $error("status word not restored from stack");
  a_cnt_high: assert property (pop_sr_done |=>
    program_counter[19:16] == $past(mem_rdata[RRX_SR_PCHI_LSB +: 4]))
    else $error("counter top bits not restored");
  a_stack_step: assert property ((pop_sr_done || pop_cnt_done) |=>
    stack_pointer == $past(stack_pointer) + RRX_SP_STEP)
    else $error("stack pointer not stepped by two");
  a_cnt_low: assert property (pop_cnt_done |=>
    program_counter == {$past(program_counter[19:16]), $past(mem_rdata)})
    else $error("full counter not formed");
  a_pop_addr: assert property (mem_req |-> mem_addr == stack_pointer)
    else $error("pop address differs from stack pointer");
  a_ret_flags: assert property (pop_cnt_done |=> $stable(status_word))
    else $error("flags changed during counter pop");
  a_ret_mode: assert property (pop_sr_done |=>
    status_word[RRX_SR_OSC_OFF:RRX_SR_IRQ_EN] ==
    $past(mem_rdata[RRX_SR_OSC_OFF:RRX_SR_IRQ_EN]))
    else $error("mode bits not restored");
  a_shift_word: assert property (shift_go && !byte_go |=>
    result == {$past(operand[14:0]), 1'b0})
    else $error("word shift result wrong");
  a_ovf_word: assert property (shift_go && !byte_go |=>
    status_word[RRX_SR_V] ==
    ($past(operand) >= RRX_OVF_W_LO && $past(operand) < RRX_OVF_W_HI))
    else $error("word overflow wrong");
  a_ovf_byte: assert property (shift_go && byte_go |=>
    status_word[RRX_SR_V] ==
    ($past(operand[7:0]) >= RRX_OVF_B_LO && $past(operand[7:0]) < RRX_OVF_B_HI))
    else $error("byte overflow wrong");
  a_neg_flag: assert property (shift_go |=>
    status_word[RRX_SR_N] == ($past(byte_go) ? result[7] : result[15]))
    else $error("negative flag wrong");
  a_zero_flag: assert property (shift_go |=>
    status_word[RRX_SR_Z] == (result == 16'h0000))
    else $error("zero flag wrong");
  a_carry_flag: assert property (shift_go |=>
    status_word[RRX_SR_C] == ($past(byte_go) ? $past(operand[7]) : $past(operand[15])))
    else $error("carry flag wrong");
  a_mode_keep: assert property (shift_go |=>
    $stable(status_word[RRX_SR_OSC_OFF:RRX_SR_IRQ_EN]))
    else $error("shift touched mode bits");
  a_byte_top: assert property (shift_go && byte_go |=>
    status_word[RRX_SR_N] == result[7] && result[15:8] == 8'h00)
    else $error("byte form top bit wrong");

  c_return_done: cover property (pop_sr_done ##[1:20] pop_cnt_done);
  c_word_ovf: cover property (shift_go && !byte_go && sh_v);
  c_byte_zero: cover property (shift_go && byte_go && sh_z);
  c_irq_raised: cover property (irq);

endmodule

//--- bench/rrx_stack_model.sv
`timescale 1ns/1ps
module rrx_stack_model (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic mem_req, // Read request
  input wire logic [19:0] mem_addr, // Word address
  input wire logic [3:0] lat, // Answer delay in cycles
  output logic mem_ack, // Read done pulse
  output logic [15:0] mem_rdata // Read word
);
  logic [15:0] mem [0:15];
  logic [3:0] cnt;

  // Data valid only with ack, held while the delay counts, toggles otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h5a5a;
      cnt <= 4'h0;
    end else if (mem_req && !mem_ack) begin
      if (cnt == lat) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem[mem_addr[4:1]];
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
  import rrx_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic mem_req, mem_ack, busy, irq;
  logic [19:0] mem_addr, program_counter, stack_pointer;
  logic [15:0] mem_rdata, status_word;
  logic [3:0] lat;
  int errors = 0;
  int tests_run = 0;

  always #5 pclk = ~pclk;

  rrx_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .program_counter(program_counter),
    .stack_pointer(stack_pointer), .status_word(status_word), .busy(busy), .irq(irq));

  rrx_stack_model STK (.clk(pclk), .rst_n(presetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends when pready is high; the watchdog ends it if pready never rises
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, r, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rdc("status", RRX_OFF_STATUS, 32'h0);
    rdc("counter", RRX_OFF_COUNTER, 32'h0);
    apb(1'b0, 8'hfc, 32'h0, r, e);
    chk("slverr", {31'h0, e}, 32'h1);
    chk("unmapped", r, 32'h0);
  endtask

  task automatic t_shift(input logic [15:0] op, input logic byt);
    logic [15:0] res, s;
    res = byt ? {8'h00, op[6:0], 1'b0} : {op[14:0], 1'b0};
    s = 16'h0038;
    s[RRX_SR_C] = byt ? op[7] : op[15];
    s[RRX_SR_Z] = (res == 16'h0000);
    s[RRX_SR_N] = byt ? res[7] : res[15];
    s[RRX_SR_V] = byt ? (op[7:0] >= 8'h40 && op[7:0] < 8'hc0)
                      : (op >= 16'h4000 && op < 16'hc000);
    wr(RRX_OFF_STATUS, 32'h38);
    wr(RRX_OFF_OPERAND, {16'h0, op});
    wr(RRX_OFF_CTRL, byt ? 32'h6 : 32'h2);
    rdc("result", RRX_OFF_RESULT, {16'h0, res});
    rdc("flags", RRX_OFF_STATUS, {16'h0, s});
  endtask

  task automatic t_return(input logic [3:0] l, input logic [19:0] sp0,
                          input logic [15:0] sr, input logic [15:0] lo);
    lat <= l;
    wr(RRX_OFF_STACK, {12'h0, sp0});
    STK.mem[sp0[4:1]] = sr;
    STK.mem[sp0[4:1] + 4'h1] = lo;
    wr(RRX_OFF_IRQ_STAT, 32'hf);
    // Return bit wins over shift bit
    wr(RRX_OFF_CTRL, 32'h3);
    // Refused while the return is running
    wr(RRX_OFF_STACK, 32'h0);
    chk("busy", {31'h0, busy}, 32'h1);
    chk("stack request", {31'h0, mem_req}, 32'h1);
    // Ends when busy falls; the watchdog ends it if busy never falls
    while (busy !== 1'b0) begin
      @(posedge pclk);
    end
    chk("stack request", {31'h0, mem_req}, 32'h0);
    chk("counter", {12'h0, program_counter}, {12'h0, sr[15:12], lo});
    chk("stack", {12'h0, stack_pointer}, {12'h0, sp0 + 20'h4});
    chk("status", {16'h0, status_word}, {16'h0, sr & RRX_SR_MASK});
    rdc("done", RRX_OFF_IRQ_STAT, 32'h1);
  endtask

  task automatic t_irq();
    wr(RRX_OFF_IRQ_MASK, 32'h0);
    wr(RRX_OFF_IRQ_STAT, 32'hf);
    wr(RRX_OFF_OPERAND, 32'h4000);
    wr(RRX_OFF_CTRL, 32'h2);
    rdc("events", RRX_OFF_IRQ_STAT, 32'h6);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(RRX_OFF_IRQ_MASK, 32'h4);
    repeat (2) @(posedge pclk);
    chk("irq on", {31'h0, irq}, 32'h1);
    wr(RRX_OFF_IRQ_STAT, 32'h4);
    repeat (2) @(posedge pclk);
    chk("irq off", {31'h0, irq}, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lat = 4'h0;
    repeat (5) @(posedge pclk);
    chk("pready", {31'h0, pready}, 32'h0);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_shift(16'h3fff, 1'b0);
    t_shift(16'h4000, 1'b0);
    t_shift(16'hbfff, 1'b0);
    t_shift(16'hc000, 1'b0);
    t_shift(16'h8000, 1'b0);
    t_shift(16'h0000, 1'b0);
    t_shift(16'hab3f, 1'b1);
    t_shift(16'h0040, 1'b1);
    t_shift(16'h12bf, 1'b1);
    t_shift(16'h00c0, 1'b1);
    t_shift(16'hff80, 1'b1);
    t_shift(16'hff00, 1'b1);
    t_return(4'h0, 20'h4, 16'h5f27, 16'h89ab);
    t_return(4'h3, 20'h8, 16'hf038, 16'h0010);
    t_irq();
    end_sim();
  end

  initial begin
    #100000;
    errors++;
    $display("unexpected run length: expected end, seen timeout");
    end_sim();
  end
endmodule
